// ==== include/cpu_regs_pkg.sv ====
package cpu_regs_pkg;
  // Stack page high bytes selected by the page bit
  localparam logic [7:0] STACK_PAGE0_HI = 8'h00;
  localparam logic [7:0] STACK_PAGE1_HI = 8'h01;
  // Reset values of the register set
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] IDX_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'hff;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] STATUS_RST = 8'h04;
  localparam logic [7:0] MODE_RST = 8'h00;
  // Field positions
  localparam int BREAK_BIT = 4;
  localparam int STACK_PAGE_BIT = 2;
  localparam int CLK_SEL_LO = 6;
  // Operations the sequencer may ask for
  typedef enum logic [3:0] {
    OP_NONE,
    OP_PUSH_ACC,
    OP_POP_ACC,
    OP_PUSH_STATUS,
    OP_POP_STATUS,
    OP_BREAK_PUSH,
    OP_PUSH_PC_HI,
    OP_PUSH_PC_LO,
    OP_POP_PC_HI,
    OP_POP_PC_LO,
    OP_FAST_SET,
    OP_SHIFT_WORD,
    OP_STOP_OSC,
    OP_WAIT,
    OP_MULTIPLY,
    OP_DIVIDE
  } op_t;
  // Register write selects
  typedef enum logic [2:0] {
    WR_NONE,
    WR_ACC,
    WR_X,
    WR_Y,
    WR_SP,
    WR_STATUS,
    WR_MODE
  } wsel_t;
endpackage

// ==== include/stack_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Carries stack pointer and page bit to the address former
interface stack_if;
  logic [7:0] sp;
  logic page_sel;
  logic [15:0] addr;
  modport core (output sp, output page_sel, input addr);
  modport former (input sp, input page_sel, output addr);
endinterface
`default_nettype wire

// ==== design/stack_addr_former.sv ====
`timescale 1ns/1ns
`default_nettype none
// Combinational stack address from pointer and page bit
module stack_addr_former (
  stack_if.former st
);
  import cpu_regs_pkg::*;
  always_comb begin
    st.addr[7:0] = st.sp;
    st.addr[15:8] = st.page_sel ? STACK_PAGE1_HI : STACK_PAGE0_HI;
  end
endmodule
`default_nettype wire

// ==== design/cpu_reg_core.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpu_reg_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire cpu_regs_pkg::op_t op,
  input wire cpu_regs_pkg::wsel_t wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_val,
  input wire logic pc_step,
  input wire logic [7:0] operand,
  input wire logic idx_use_y,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  output logic [15:0] eff_addr,
  output logic [7:0] acc,
  output logic [7:0] idx_x,
  output logic [7:0] idx_y,
  output logic [7:0] stack_ptr,
  output logic [7:0] status,
  output logic [7:0] mode,
  output logic [7:0] pc_high_byte,
  output logic [7:0] pc_low_byte,
  output logic illegal_op,
  output logic stop_req,
  output logic wait_req,
  output logic [15:0] product
);
  import cpu_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Internal state
  logic [7:0] acc_r; // Accumulator
  logic [7:0] x_r; // Index X
  logic [7:0] y_r; // Index Y
  logic [7:0] sp_r; // Stack pointer
  logic [7:0] ps_r; // Status, break bit always zero inside
  logic [7:0] mode_r; // Mode register with stack page bit
  logic [15:0] pc_r; // Program counter
  logic pop_pend_r; // Pop read issued last cycle
  op_t pop_op_r; // Which pop is completing
  stack_if st ();
  logic rst_meta_b_r; // First stage of the reset release
  logic rst_sync_b_r; // Released reset seen by every other flop
  // Pin reset asserts at once but releases two edges late, so no flop
  // but these two sees the pin's rise close to a clock edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b_r <= 1'b0;
      rst_sync_b_r <= 1'b0;
    end else begin
      rst_meta_b_r <= 1'b1;
      rst_sync_b_r <= rst_meta_b_r;
    end
  end
  assign st.sp = sp_r;
  assign st.page_sel = mode_r[STACK_PAGE_BIT];
  stack_addr_former u_former (
    .st(st)
  );
  // Decoding helpers
  function automatic logic is_push(input op_t o);
    return o inside {OP_PUSH_ACC, OP_PUSH_STATUS, OP_BREAK_PUSH,
                     OP_PUSH_PC_HI, OP_PUSH_PC_LO};
  endfunction
  function automatic logic is_pop(input op_t o);
    return o inside {OP_POP_ACC, OP_POP_STATUS, OP_POP_PC_HI, OP_POP_PC_LO};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer: post-decrement push, pre-increment pop
  always_ff @(posedge clk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      sp_r <= SP_RST;
    end else if (is_push(op)) begin
      sp_r <= sp_r - 8'h01;
    end else if (is_pop(op)) begin
      sp_r <= sp_r + 8'h01;
    end else if (wr_sel == WR_SP) begin
      sp_r <= wr_data;
    end
  end

  // Memory strobe for push writes and pop reads
  // Pop reads at pointer plus one, so the address is formed from the sum
  always_ff @(posedge clk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
    end else begin
      mem_we <= is_push(op);
      mem_re <= is_pop(op);
      if (is_push(op)) begin
        mem_addr <= st.addr;
      end else if (is_pop(op)) begin
        mem_addr <= {st.addr[15:8], sp_r + 8'h01};
      end
      case (op)
        OP_PUSH_ACC: mem_wdata <= acc_r;
        OP_PUSH_STATUS: mem_wdata <= ps_r;
        OP_BREAK_PUSH: mem_wdata <= ps_r | (8'h01 << BREAK_BIT);
        OP_PUSH_PC_HI: mem_wdata <= pc_r[15:8];
        OP_PUSH_PC_LO: mem_wdata <= pc_r[7:0];
        default: mem_wdata <= mem_wdata;
      endcase
    end
  end

  // Remember which pop is waiting for read data
  always_ff @(posedge clk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      pop_pend_r <= 1'b0;
      pop_op_r <= OP_NONE;
    end else begin
      pop_pend_r <= is_pop(op);
      pop_op_r <= op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and index registers
  always_ff @(posedge clk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      acc_r <= ACC_RST;
      x_r <= IDX_RST;
      y_r <= IDX_RST;
    end else begin
      if (pop_pend_r && pop_op_r == OP_POP_ACC) begin
        acc_r <= mem_rdata;
      end else if (wr_sel == WR_ACC) begin
        acc_r <= wr_data;
      end
      if (wr_sel == WR_X) begin
        x_r <= wr_data;
      end
      if (wr_sel == WR_Y) begin
        y_r <= wr_data;
      end
    end
  end

  // Status and mode; break flag is never stored as one
  always_ff @(posedge clk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      ps_r <= STATUS_RST;
      mode_r <= MODE_RST;
    end else begin
      if (pop_pend_r && pop_op_r == OP_POP_STATUS) begin
        ps_r <= mem_rdata & ~(8'h01 << BREAK_BIT);
      end else if (wr_sel == WR_STATUS) begin
        ps_r <= wr_data & ~(8'h01 << BREAK_BIT);
      end
      if (wr_sel == WR_MODE) begin
        mode_r <= wr_data;
      end
    end
  end

  // Program counter with load, step and byte pops
  always_ff @(posedge clk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      pc_r <= PC_RST;
    end else if (pop_pend_r && pop_op_r == OP_POP_PC_HI) begin
      pc_r[15:8] <= mem_rdata;
    end else if (pop_pend_r && pop_op_r == OP_POP_PC_LO) begin
      pc_r[7:0] <= mem_rdata;
    end else if (pc_load) begin
      pc_r <= pc_load_val;
    end else if (pc_step) begin
      pc_r <= pc_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indexed effective address, zero-page carry kept in bit 8
  always_ff @(posedge clk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      eff_addr <= 16'h0000;
    end else if (idx_use_y) begin
      eff_addr <= {8'h00, operand} + {8'h00, y_r};
    end else begin
      eff_addr <= {8'h00, operand} + {8'h00, x_r};
    end
  end

  // Optional instruction support; unsupported ones are flagged
  always_ff @(posedge clk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      illegal_op <= 1'b0;
      stop_req <= 1'b0;
      wait_req <= 1'b0;
      product <= 16'h0000;
    end else begin
      illegal_op <= (op == OP_FAST_SET) || (op == OP_SHIFT_WORD);
      stop_req <= (op == OP_STOP_OSC);
      wait_req <= (op == OP_WAIT);
      case (op)
        OP_MULTIPLY: product <= acc_r * x_r;
        OP_DIVIDE: begin
          // Divide by zero returns all ones rather than trapping
          if (x_r == 8'h00) product <= 16'hffff;
          else product <= {acc_r % x_r, acc_r / x_r};
        end
        default: product <= product;
      endcase
    end
  end

  // Register outputs
  assign acc = acc_r;
  assign idx_x = x_r;
  assign idx_y = y_r;
  assign stack_ptr = sp_r;
  assign status = ps_r;
  assign mode = mode_r;
  assign pc_high_byte = pc_r[15:8];
  assign pc_low_byte = pc_r[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_push;
    is_push(op);
  endsequence
  property p_push_addr;
    @(posedge clk) disable iff (!rst_sync_b_r)
      s_push |=> mem_we && mem_addr[7:0] == stack_ptr + 8'h01;
  endproperty
  a_push_addr: assert property (p_push_addr)
    else $error("push address not old pointer");
  property p_pop_addr;
    @(posedge clk) disable iff (!rst_sync_b_r)
      is_pop(op) |=> mem_re && mem_addr[7:0] == stack_ptr;
  endproperty
  a_pop_addr: assert property (p_pop_addr)
    else $error("pop address not incremented pointer");
  property p_page_hi;
    @(posedge clk) disable iff (!rst_sync_b_r)
      st.addr[15:8] == (mode_r[STACK_PAGE_BIT] ? 8'h01 : 8'h00);
  endproperty
  a_page_hi: assert property (p_page_hi)
    else $error("stack page byte wrong");
  property p_low_sp;
    @(posedge clk) disable iff (!rst_sync_b_r) st.addr[7:0] == sp_r;
  endproperty
  a_low_sp: assert property (p_low_sp)
    else $error("stack low byte differs from pointer");
  property p_brk;
    @(posedge clk) disable iff (!rst_sync_b_r)
      op == OP_BREAK_PUSH |=> mem_wdata[BREAK_BIT];
  endproperty
  a_brk: assert property (p_brk)
    else $error("break push without flag");
  property p_brk_zero;
    @(posedge clk) disable iff (!rst_sync_b_r) !ps_r[BREAK_BIT];
  endproperty
  a_brk_zero: assert property (p_brk_zero)
    else $error("break flag held as one");
  property p_x_idx;
    @(posedge clk) disable iff (!rst_sync_b_r)
      !idx_use_y |=> eff_addr == {8'h00, $past(operand)} + {8'h00, $past(x_r)};
  endproperty
  a_x_idx: assert property (p_x_idx)
    else $error("x indexed address wrong");
  property p_illegal;
    @(posedge clk) disable iff (!rst_sync_b_r)
      op inside {OP_FAST_SET, OP_SHIFT_WORD} |=> illegal_op ##1 !illegal_op
      or op inside {OP_FAST_SET, OP_SHIFT_WORD};
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("unsupported op not flagged");
  property p_pc_step;
    @(posedge clk) disable iff (!rst_sync_b_r)
      pc_step && !pc_load && !pop_pend_r |=> pc_r == $past(pc_r) + 16'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("pc did not step");
endmodule
`default_nettype wire

// ==== test/cpu_register_stack_addressing_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpu_register_stack_addressing_test;
  import cpu_regs_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic clk = 1'b0; // 50 MHz system clock
  logic rst_b = 1'b0; // Held low at start
  op_t op = OP_NONE;
  wsel_t wr_sel = WR_NONE;
  logic [7:0] wr_data = 8'h00, operand = 8'h00, mem_rdata = 8'h00;
  logic pc_load = 1'b0, pc_step = 1'b0, idx_use_y = 1'b0;
  logic [15:0] pc_load_val = 16'h0000;
  logic [15:0] mem_addr, eff_addr, product;
  logic [7:0] mem_wdata, acc, idx_x, idx_y, stack_ptr, status, mode;
  logic [7:0] pc_high_byte, pc_low_byte;
  logic mem_we, mem_re, illegal_op, stop_req, wait_req;
  int num_errors = 0; // Mismatches seen
  int num_checks = 0; // Comparisons made
  always #10 clk = ~clk;
  cpu_reg_core i_dut (.clk(clk), .rst_b(rst_b), .op(op), .wr_sel(wr_sel),
    .wr_data(wr_data), .pc_load(pc_load), .pc_load_val(pc_load_val),
    .pc_step(pc_step), .operand(operand), .idx_use_y(idx_use_y),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .eff_addr(eff_addr), .acc(acc),
    .idx_x(idx_x), .idx_y(idx_y), .stack_ptr(stack_ptr), .status(status),
    .mode(mode), .pc_high_byte(pc_high_byte), .pc_low_byte(pc_low_byte),
    .illegal_op(illegal_op), .stop_req(stop_req), .wait_req(wait_req),
    .product(product));
  ////////////////////////////////////////////////////////////////////////////
  // Compare one value, count it, report a mismatch at once
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One cycle: inputs change 2 ns after the edge, results settled then
  task automatic step(input op_t o, input wsel_t s, input logic [7:0] d);
    op = o;
    wr_sel = s;
    wr_data = d;
    @(posedge clk);
    #2;
  endtask
  // Single place where the run ends
  task automatic complete_run;
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Pushes on both pages, break push, back-to-back pops
  task automatic t_stack;
    step(OP_NONE, WR_ACC, 8'h5a);
    step(OP_PUSH_ACC, WR_NONE, 8'h00);
    chk(mem_we, 1'b1);
    chk(mem_addr, 16'h00ff);
    chk(mem_wdata, 8'h5a);
    chk(stack_ptr, 8'hfe);
    step(OP_NONE, WR_MODE, 8'h04);
    chk(mode, 8'h04);
    step(OP_PUSH_STATUS, WR_NONE, 8'h00);
    chk(mem_addr, 16'h01fe);
    chk(mem_wdata, 8'h04);
    step(OP_BREAK_PUSH, WR_NONE, 8'h00);
    chk({mem_addr, mem_wdata}, 24'h01fd14);
    chk({stack_ptr, status}, 16'hfc04);
    step(OP_POP_STATUS, WR_NONE, 8'h00);
    chk({mem_re, mem_we}, 2'b10);
    chk({mem_addr, stack_ptr}, 24'h01fdfd);
    mem_rdata = 8'hc3;
    step(OP_POP_ACC, WR_NONE, 8'h00);
    chk(status, 8'hc3);
    chk(mem_addr, 16'h01fe);
    mem_rdata = 8'ha1;
    step(OP_POP_ACC, WR_NONE, 8'h00);
    chk(acc, 8'ha1);
    chk(mem_addr, 16'h01ff);
    mem_rdata = 8'hb2;
    step(OP_NONE, WR_NONE, 8'h00);
    // Released data line shows a changed value, never a stale one
    mem_rdata = 8'h4d;
    chk({acc, stack_ptr}, 16'hb2ff);
    chk(mem_re, 1'b0);
  endtask
  // Indexed address with carry into the high byte
  task automatic t_index;
    step(OP_NONE, WR_X, 8'hf0);
    step(OP_NONE, WR_Y, 8'h22);
    operand = 8'h20;
    step(OP_NONE, WR_NONE, 8'h00);
    chk(eff_addr, 16'h0110);
    idx_use_y = 1'b1;
    step(OP_NONE, WR_NONE, 8'h00);
    chk(eff_addr, 16'h0042);
  endtask
  // Counter crosses a byte boundary, then is pushed high byte first
  task automatic t_pc;
    pc_load = 1'b1;
    pc_load_val = 16'h12ff;
    step(OP_NONE, WR_NONE, 8'h00);
    pc_load = 1'b0;
    pc_step = 1'b1;
    step(OP_NONE, WR_NONE, 8'h00);
    pc_step = 1'b0;
    chk({pc_high_byte, pc_low_byte}, 16'h1300);
    step(OP_PUSH_PC_HI, WR_NONE, 8'h00);
    chk({mem_addr, mem_wdata}, 24'h01ff13);
    step(OP_PUSH_PC_LO, WR_NONE, 8'h00);
    chk({mem_addr, mem_wdata}, 24'h01fe00);
    // Pop low byte then high byte over a freshly loaded counter
    pc_load = 1'b1;
    pc_load_val = 16'hbeef;
    step(OP_POP_PC_LO, WR_NONE, 8'h00);
    pc_load = 1'b0;
    chk({mem_re, mem_addr}, 17'h101fe);
    mem_rdata = 8'h00;
    step(OP_POP_PC_HI, WR_NONE, 8'h00);
    chk({pc_high_byte, pc_low_byte}, 16'hbe00);
    chk(mem_addr, 16'h01ff);
    mem_rdata = 8'h13;
    step(OP_NONE, WR_NONE, 8'h00);
    chk({pc_high_byte, pc_low_byte, stack_ptr}, 24'h1300ff);
    // Direct pointer write, then a push that outranks it
    step(OP_NONE, WR_SP, 8'h80);
    chk(stack_ptr, 8'h80);
    step(OP_PUSH_ACC, WR_SP, 8'h10);
    chk({mem_addr, stack_ptr}, 24'h01807f);
  endtask
  // Refused and supported operations
  task automatic t_ops;
    step(OP_NONE, WR_ACC, 8'h17);
    step(OP_NONE, WR_X, 8'h05);
    step(OP_FAST_SET, WR_NONE, 8'h00);
    chk({illegal_op, acc}, 9'h117);
    step(OP_SHIFT_WORD, WR_NONE, 8'h00);
    chk({illegal_op, acc}, 9'h117);
    step(OP_MULTIPLY, WR_NONE, 8'h00);
    chk({illegal_op, product}, 17'h00073);
    step(OP_DIVIDE, WR_NONE, 8'h00);
    chk(product, 16'h0304);
    step(OP_STOP_OSC, WR_X, 8'h00);
    chk({stop_req, wait_req}, 2'b10);
    step(OP_WAIT, WR_NONE, 8'h00);
    chk({stop_req, wait_req}, 2'b01);
    step(OP_DIVIDE, WR_NONE, 8'h00);
    chk({wait_req, product}, 17'h0ffff);
  endtask
  // Reset values, and a reset in mid-run taking hold at once
  task automatic t_reset(input logic mid);
    if (mid) begin
      rst_b = 1'b0;
      #5;
    end
    chk({acc, idx_x, idx_y, mode}, 32'h0);
    chk({stack_ptr, status}, 16'hff04);
    chk({pc_high_byte, pc_low_byte, mem_we}, 17'h0);
    if (mid) begin
      step(OP_NONE, WR_NONE, 8'h00);
      rst_b = 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    #2;
    t_reset(1'b0);
    rst_b = 1'b1;
    // Internal reset lets go two edges after the pin
    step(OP_NONE, WR_NONE, 8'h00);
    step(OP_NONE, WR_NONE, 8'h00);
    t_stack;
    t_index;
    t_pc;
    t_ops;
    t_reset(1'b1);
    step(OP_NONE, WR_NONE, 8'h00);
    step(OP_NONE, WR_NONE, 8'h00);
    // Same stack walk after the mid-run reset has let go
    t_stack;
    complete_run;
  end
  // Watchdog: tests need well under 200 cycles
  initial begin
    #40000;
    num_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
